// ===== tww_master.sv
// tww_master: two-wire master transmitter, software steps plus bus sequencer
// assumes open-drain scl/sda resolved outside, a free-running bit clock link_clk
`timescale 1ns/1ps
// Function
// RULE1 - software requests start with flag clear
// RULE2 - start when bus free, post 0x08
// RULE3 - address direction bit picks send/receive mode
// RULE4 - software loads address then clears flag
// RULE5 - address result posts 0x18, 0x20, 0x38
// RULE6 - data write without flag discarded, collision set
// RULE7 - plain clear after step sends data byte
// RULE8 - data result posts 0x28 or 0x30
// RULE9 - begin only gives repeated start, 0x10
// RULE10 - halt only sends stop, halt self-clears
// RULE11 - both send stop then start
// RULE12 - at 0x08 address sent, ack_on ignored
// RULE13 - after 0x10 address choice sets mode
// RULE14 - arbitration loss posts 0x38, release or restart
// RULE15 - lost and addressed gives slave entry 0xb0
// RULE16 - status low bits read zero
// RULE17 - flag set holds transfer suspended
// RULE18 - software masks status with 0xf8
// RULE19 - direction bit low write, high read
module tww_master import tww_pkg::*; #(
	parameter logic [6:0] OWN_ADDR = 7'h2a // own slave address, arbitrary
) (
	// clocks and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	// software side
	input wire logic ctrl_wr,
	input wire tww_ctrl_s ctrl_in,
	input wire logic data_wr,
	input wire logic [7:0] data_in,
	// software read-back
	output logic [7:0] bus_status_reg,
	output logic [7:0] bus_data_reg,
	output logic step_done,
	output logic write_collision_flag,
	output logic halt_column,
	output logic begin_column,
	output logic ack_on_bit,
	output logic master_send_mode,
	output logic master_receive_mode,
	output logic slave_entry,
	// bus pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);
	// ------------------------------------------------------------
	// system side
	// ------------------------------------------------------------
	tww_cmd_s cmd_r; // held stable while pending
	tww_res_s res_r; // link result, stable until the next result
	logic req_tgl_r; // command event toggle
	logic res_tgl_r; // result event toggle, link domain
	logic rs1_r, rs2_r, rs3_r; // result toggle synchroniser
	logic pend_r; // command outstanding
	logic res_ev; // result arrived
	logic issue; // software step accepted
	tww_op_e op_nxt; // operation chosen for this step
	logic rel; // release after loss, no bus action
	assign res_ev = rs2_r ^ rs3_r;
	// result toggle crossing
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
			rs3_r <= 1'b0;
		end else begin
			rs1_r <= res_tgl_r;
			rs2_r <= rs1_r;
			rs3_r <= rs2_r;
		end
	end
	// step decision from status and control bits
	always_comb begin
		op_nxt = OP_NONE;
		rel = 1'b0;
		case (bus_status_reg)
			ST_IDLE: op_nxt = ctrl_in.begin_column ? OP_START : OP_NONE; // RULE1
			ST_ARB: begin
				op_nxt = ctrl_in.begin_column ? OP_START : OP_NONE; // RULE14
				rel = ~ctrl_in.begin_column; // RULE14
			end
			ST_START, ST_RSTART: op_nxt = OP_SEND; // RULE12 RULE13
			ST_AW_ACK, ST_AW_NAK, ST_D_ACK, ST_D_NAK, ST_AR_ACK, ST_AR_NAK: begin
				if (ctrl_in.begin_column && ctrl_in.halt_column)
					op_nxt = OP_STOPSTART; // RULE11
				else if (ctrl_in.halt_column)
					op_nxt = OP_STOP; // RULE10
				else if (ctrl_in.begin_column)
					op_nxt = OP_START; // RULE9
				else
					op_nxt = OP_SEND; // RULE7
			end
			default: op_nxt = OP_NONE; // slave entry: master logic idle
		endcase
	end
	// RULE17
	assign issue = ctrl_wr & ctrl_in.clear & ctrl_in.enable & ~pend_r & ~res_ev
		& (step_done | bus_status_reg == ST_IDLE);
	// command launch, one toggle per step
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_r <= '{op: OP_NONE, addr: 1'b0, data: 8'h00};
			req_tgl_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			if (issue && op_nxt != OP_NONE) begin
				cmd_r <= '{op: op_nxt, addr: (bus_status_reg == ST_START || bus_status_reg == ST_RSTART),
					data: bus_data_reg};
				req_tgl_r <= ~req_tgl_r;
				pend_r <= 1'b1;
			end else if (res_ev) begin
				pend_r <= 1'b0;
			end
		end
	end
	// step-done flag, a set wins over a clear
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			step_done <= 1'b0;
		else if (res_ev && res_r.post)
			step_done <= 1'b1; // RULE2 RULE5 RULE8
		else if (ctrl_wr && ctrl_in.clear)
			step_done <= 1'b0; // RULE17
	end
	// status code, prescaler bits forced to zero
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			bus_status_reg <= ST_IDLE;
		else if (res_ev)
			bus_status_reg <= res_r.code & ST_CODE_MASK; // RULE16
		else if (issue && rel)
			bus_status_reg <= ST_IDLE; // RULE14
	end
	// control bits; the block clears halt itself when the stop is out
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			begin_column <= 1'b0;
			halt_column <= 1'b0;
			ack_on_bit <= 1'b0;
		end else if (ctrl_wr) begin
			begin_column <= ctrl_in.begin_column;
			halt_column <= ctrl_in.halt_column;
			ack_on_bit <= ctrl_in.ack_on_bit;
		end else if (res_ev && res_r.stop) begin
			halt_column <= 1'b0; // RULE10 RULE11
		end
	end
	// data register with write-collision guard
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_data_reg <= 8'h00;
			write_collision_flag <= 1'b0;
		end else if (data_wr && step_done) begin
			bus_data_reg <= data_in; // RULE4
			write_collision_flag <= 1'b0;
		end else if (data_wr) begin
			write_collision_flag <= 1'b1; // RULE6
		end
	end
	// mode flags follow the posted code
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			master_send_mode <= 1'b0;
			master_receive_mode <= 1'b0;
			slave_entry <= 1'b0;
		end else if (res_ev && !res_r.stop) begin
			master_send_mode <= res_r.code == ST_AW_ACK || res_r.code == ST_AW_NAK
				|| (master_send_mode && (res_r.code == ST_D_ACK || res_r.code == ST_D_NAK)); // RULE3
			master_receive_mode <= res_r.code == ST_AR_ACK || res_r.code == ST_AR_NAK; // RULE3 RULE13
			slave_entry <= res_r.code == ST_SLV; // RULE15
		end else if (res_ev) begin
			master_send_mode <= 1'b0;
			master_receive_mode <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// link side, on link_clk
	// ------------------------------------------------------------
	logic lrst1_r, lrst_r; // reset released in link domain
	logic q1_r, q2_r, q3_r; // command toggle synchroniser
	logic scl1_r, scl_s, scl_q; // scl synchroniser and history
	logic sda1_r, sda_s, sda_q; // sda synchroniser and history
	logic busy_r; // a start seen on the wire, ours included, and no stop since
	logic owner_r; // we hold the bus
	tww_lst_e st_r; // sequencer state
	logic [1:0] ph_r; // quarter of a bit
	logic [3:0] cnt_r; // bit index, 8 is acknowledge
	logic [7:0] sh_r; // outgoing byte
	logic [7:0] rx_r; // bits seen on the wire
	logic stst_r; // start follows the stop
	logic lbit; // level we put on sda this bit
	logic req_ev; // command arrived
	assign req_ev = q2_r ^ q3_r;
	assign lbit = (cnt_r == BIT_ACK) ? 1'b1 : sh_r[7];
	// link reset synchroniser, asserts at once, releases on link_clk
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lrst1_r <= 1'b1;
			lrst_r <= 1'b1;
		end else begin
			lrst1_r <= 1'b0;
			lrst_r <= lrst1_r;
		end
	end
	// pin and command synchronisers
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			{q1_r, q2_r, q3_r} <= 3'b000;
			{scl1_r, scl_s, scl_q} <= 3'b111;
			{sda1_r, sda_s, sda_q} <= 3'b111;
		end else begin
			{q1_r, q2_r, q3_r} <= {req_tgl_r, q1_r, q2_r};
			{scl1_r, scl_s, scl_q} <= {scl_in, scl1_r, scl_s};
			{sda1_r, sda_s, sda_q} <= {sda_in, sda1_r, sda_s};
		end
	end
	// bus busy from start and stop seen on the wire, ours included
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r)
			busy_r <= 1'b0;
		else if (scl_s && scl_q && sda_q && !sda_s)
			busy_r <= 1'b1;
		else if (scl_s && scl_q && !sda_q && sda_s)
			busy_r <= 1'b0;
	end
	// bus sequencer
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			st_r <= L_IDLE;
			ph_r <= 2'd0;
			cnt_r <= 4'd0;
			sh_r <= 8'h00;
			rx_r <= 8'h00;
			stst_r <= 1'b0;
			owner_r <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			res_r <= '{code: ST_IDLE, post: 1'b0, stop: 1'b0};
			res_tgl_r <= 1'b0;
		end else begin
			case (st_r)
				// wait for a command
				L_IDLE: if (req_ev) begin
					ph_r <= 2'd0;
					cnt_r <= 4'd0;
					sh_r <= cmd_r.data; // RULE19
					stst_r <= cmd_r.op == OP_STOPSTART;
					case (cmd_r.op)
						OP_START: st_r <= L_START;
						OP_SEND: st_r <= L_BIT;
						OP_STOP, OP_STOPSTART: st_r <= L_STOP;
						default: st_r <= L_IDLE;
					endcase
				end
				// start or repeated start
				L_START: case (ph_r)
					2'd0: begin
						sda_oe_n <= 1'b1;
						if (owner_r || !busy_r)
							ph_r <= 2'd1; // RULE2 RULE14
					end
					2'd1: begin
						scl_oe_n <= 1'b1;
						ph_r <= 2'd2;
					end
					2'd2: if (scl_s && (owner_r || sda_s)) begin
						sda_oe_n <= 1'b0;
						ph_r <= 2'd3;
					end
					default: begin
						scl_oe_n <= 1'b0;
						owner_r <= 1'b1;
						res_r <= '{code: owner_r ? ST_RSTART : ST_START, post: 1'b1, stop: 1'b0}; // RULE2 RULE9
						res_tgl_r <= ~res_tgl_r;
						st_r <= L_IDLE;
					end
				endcase
				// one address, data or acknowledge bit
				L_BIT: case (ph_r)
					2'd0: begin
						sda_oe_n <= lbit; // RULE19
						ph_r <= 2'd1;
					end
					2'd1: begin
						scl_oe_n <= 1'b1;
						ph_r <= 2'd2;
					end
					2'd2: if (scl_s) begin
						rx_r <= {rx_r[6:0], sda_s};
						ph_r <= 2'd3;
						if (cnt_r != BIT_ACK && lbit && !sda_s) begin
							sda_oe_n <= 1'b1; // RULE14
							owner_r <= 1'b0;
							cnt_r <= cnt_r + 4'd1;
							st_r <= L_LISTEN;
						end
					end
					default: begin
						scl_oe_n <= 1'b0;
						ph_r <= 2'd0;
						cnt_r <= cnt_r + 4'd1;
						sh_r <= {sh_r[6:0], 1'b0};
						if (cnt_r == BIT_ACK) begin
							st_r <= L_IDLE;
							res_tgl_r <= ~res_tgl_r;
							if (!cmd_r.addr)
								res_r <= '{code: rx_r[0] ? ST_D_NAK : ST_D_ACK, post: 1'b1, stop: 1'b0}; // RULE8
							else if (cmd_r.data[0])
								res_r <= '{code: rx_r[0] ? ST_AR_NAK : ST_AR_ACK, post: 1'b1, stop: 1'b0}; // RULE3
							else
								res_r <= '{code: rx_r[0] ? ST_AW_NAK : ST_AW_ACK, post: 1'b1, stop: 1'b0}; // RULE5
						end
					end
				endcase
				// lost: follow the winner to the end of an address byte, a lost data byte ends at once
				L_LISTEN: begin
					scl_oe_n <= 1'b1;
					if (!cmd_r.addr || cnt_r == BIT_ACK) begin
						st_r <= L_IDLE;
						res_tgl_r <= ~res_tgl_r;
						res_r <= '{code: (cmd_r.addr && rx_r == {OWN_ADDR, 1'b1}) ? ST_SLV : ST_ARB,
							post: 1'b1, stop: 1'b0}; // RULE5 RULE14 RULE15
					end else if (scl_s && !scl_q) begin
						rx_r <= {rx_r[6:0], sda_s};
						cnt_r <= cnt_r + 4'd1;
					end
				end
				// stop, then maybe a fresh start
				L_STOP: case (ph_r)
					2'd0: begin
						sda_oe_n <= 1'b0;
						ph_r <= 2'd1;
					end
					2'd1: begin
						scl_oe_n <= 1'b1;
						ph_r <= 2'd2;
					end
					2'd2: if (scl_s) begin
						sda_oe_n <= 1'b1;
						ph_r <= 2'd3;
					end
					default: begin
						owner_r <= 1'b0;
						ph_r <= 2'd0;
						st_r <= stst_r ? L_START : L_IDLE; // RULE11
						res_r <= '{code: ST_IDLE, post: 1'b0, stop: 1'b1}; // RULE10
						res_tgl_r <= ~res_tgl_r;
					end
				endcase
				default: st_r <= L_IDLE;
			endcase
		end
	end
	// pins only ever pull low
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	flag_post_a: assert property (res_ev && res_r.post |=> step_done) else $error("flag not set"); // RULE2
	wcol_set_a: assert property (data_wr && !step_done |=> write_collision_flag && $stable(bus_data_reg))
		else $error("collision missed"); // RULE6
	suspend_a: assert property (step_done && !(ctrl_wr && ctrl_in.clear) |=> $stable(req_tgl_r))
		else $error("ran while suspended"); // RULE17
	code_low_a: assert property (bus_status_reg[1:0] == 2'b00) else $error("prescaler bits set"); // RULE16
	halt_self_a: assert property (res_ev && res_r.stop && !ctrl_wr |=> !halt_column)
		else $error("halt not cleared"); // RULE10
	addr_send_a: assert property (issue && bus_status_reg == ST_START |=> cmd_r.op == OP_SEND && cmd_r.addr)
		else $error("address not sent"); // RULE12
	mode_write_a: assert property (res_ev && res_r.code == ST_AW_ACK |=> master_send_mode && !master_receive_mode)
		else $error("send mode missed"); // RULE3
	both_stop_a: assert property (issue && bus_status_reg == ST_AW_NAK && ctrl_in.begin_column
		&& ctrl_in.halt_column |=> cmd_r.op == OP_STOPSTART) else $error("stop-start missed"); // RULE11
	lost_rel_a: assert property (@(posedge link_clk) disable iff (lrst_r)
		st_r == L_LISTEN |-> sda_oe_n && !owner_r) else $error("bus held after loss"); // RULE14
	cov_start_c: cover property (res_ev && res_r.code == ST_START);
	cov_data_c: cover property (res_ev && res_r.code == ST_D_ACK);
	cov_arb_c: cover property (res_ev && res_r.code == ST_ARB);
	cov_stop_c: cover property (res_ev && res_r.stop);
endmodule

// ===== tww_pkg.sv
// tww_pkg: constants and carriers of the two-wire master-transmitter block
// assumes two importers, the tww_master module and the testbench, and an 8-bit status code
package tww_pkg;
	// ------------------------------------------------------------
	// status codes, low two bits always zero
	// ------------------------------------------------------------
	localparam logic [7:0] ST_START = 8'h08; // start sent
	localparam logic [7:0] ST_RSTART = 8'h10; // repeated start sent
	localparam logic [7:0] ST_AW_ACK = 8'h18; // write address acked
	localparam logic [7:0] ST_AW_NAK = 8'h20; // write address not acked
	localparam logic [7:0] ST_D_ACK = 8'h28; // data acked
	localparam logic [7:0] ST_D_NAK = 8'h30; // data not acked
	localparam logic [7:0] ST_ARB = 8'h38; // arbitration lost
	localparam logic [7:0] ST_AR_ACK = 8'h40; // read address acked
	localparam logic [7:0] ST_AR_NAK = 8'h48; // read address not acked
	localparam logic [7:0] ST_SLV = 8'hb0; // lost, addressed as slave
	localparam logic [7:0] ST_IDLE = 8'hf8; // nothing to report
	localparam logic [7:0] ST_CODE_MASK = 8'hf8; // strips prescaler bits
	localparam logic [3:0] BIT_ACK = 4'h8; // index of the acknowledge bit
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	// operation handed to the link side
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_START = 3'b001,
		OP_SEND = 3'b010,
		OP_STOP = 3'b011,
		OP_STOPSTART = 3'b100
	} tww_op_e;
	// link sequencer states
	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_START = 3'b001,
		L_BIT = 3'b010,
		L_STOP = 3'b011,
		L_LISTEN = 3'b100
	} tww_lst_e;
	// a write to the control register
	typedef struct packed {
		logic enable; // interface on
		logic begin_column; // start request
		logic halt_column; // stop request
		logic clear; // one clears the step-done flag
		logic ack_on_bit; // acknowledge enable
	} tww_ctrl_s;
	// command crossing to the link clock
	typedef struct packed {
		tww_op_e op;
		logic addr; // byte is an address
		logic [7:0] data;
	} tww_cmd_s;
	// result crossing back to the system clock
	typedef struct packed {
		logic [7:0] code;
		logic post; // sets the step-done flag
		logic stop; // a stop went out
	} tww_res_s;
endpackage

// ===== tww_slave_model.sv
// tww_slave_model: behavioural far side of the two-wire bus, one slave receiver
// plus an optional rival master that drives and clocks the first byte after a start
// assumes the bench resolves scl/sda as wired-and lines with pull-ups
`timescale 1ns/1ps
module tww_slave_model (
	// bus lines as seen on the wire
	input wire logic scl,
	input wire logic sda,
	// behaviour selects from the bench
	input wire logic ack_en,
	input wire logic stretch,
	input wire logic rival_en,
	input wire logic [7:0] rival,
	// pulls, one means holding the line low
	output logic scl_pull,
	output logic sda_pull,
	// observed traffic
	output logic [7:0] last_byte,
	output logic [7:0] nbytes
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] shift_r; // bits collected msb first
	int rises; // scl rising edges in this byte
	logic first; // first byte after a start
	logic stretch_pull; // slave stretch and rival stop hold scl
	logic rival_pull; // rival clock low phase
	assign scl_pull = stretch_pull | rival_pull;
	initial begin
		stretch_pull = 1'b0;
		rival_pull = 1'b0;
		sda_pull = 1'b0;
		last_byte = 8'h00;
		nbytes = 8'h00;
		shift_r = 8'h00;
		rises = 0;
		first = 1'b0;
	end
	// ------------------------------------------------------------
	// framing: start seen while scl is high
	// ------------------------------------------------------------
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			rises = 0;
			first = 1'b1;
		end
	end
	// sample each bit on the rising clock
	always @(posedge scl) begin
		if (rises < 8) begin
			shift_r = {shift_r[6:0], sda};
		end
		rises++;
	end
	// rival clock: pulls scl low for a while after each rise of its own byte,
	// so the byte still gets clocked once the block backs off and releases scl
	always @(posedge scl) begin
		if (rival_en && first) begin
			#100;
			rival_pull = 1'b1;
			#100;
			rival_pull = 1'b0;
		end
	end
	// ------------------------------------------------------------
	// drive changes only while scl is low, except the rival's closing stop
	// ------------------------------------------------------------
	always @(negedge scl) begin
		if (rises < 8) begin
			// rival master puts its own byte on the wire
			sda_pull = rival_en & first & ~rival[7 - rises];
		end else if (rises == 8) begin
			// acknowledge slot, the rival case is left unanswered
			sda_pull = ack_en & ~rival_en;
			if (stretch) begin
				stretch_pull = 1'b1;
				#200;
				stretch_pull = 1'b0;
			end
		end else begin
			// byte done, release and record
			last_byte = shift_r;
			nbytes = nbytes + 8'h01;
			rises = 0;
			sda_pull = 1'b0;
			if (rival_en && first) begin
				// rival closes its frame with a stop so the bus is free again
				first = 1'b0;
				sda_pull = 1'b1;
				stretch_pull = 1'b1;
				#150;
				stretch_pull = 1'b0;
				#150;
				sda_pull = 1'b0;
			end
			first = 1'b0;
		end
	end
endmodule

// ===== testbench.sv
// testbench: steps the master transmitter through its status codes
// assumes tww_master with a free-running link clock and the slave model above
`timescale 1ns/1ps
module testbench;
	import tww_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic sys_clk, sys_rst, link_clk, ctrl_wr, data_wr;
	tww_ctrl_s ctrl_in;
	logic [7:0] data_in, bus_status_reg, bus_data_reg, last_byte, nbytes, rival;
	logic step_done, write_collision_flag, halt_column, begin_column, ack_on_bit;
	logic master_send_mode, master_receive_mode, slave_entry;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_pull, sda_pull;
	logic ack_en, stretch, rival_en;
	wire logic scl_line; // wired-and with pull-up
	wire logic sda_line;
	int errors, checks_done;
	assign scl_line = scl_oe_n & ~scl_pull;
	assign sda_line = sda_oe_n & ~sda_pull;
	// ------------------------------------------------------------
	// instances
	// ------------------------------------------------------------
	tww_master DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk), .ctrl_wr(ctrl_wr),
		.ctrl_in(ctrl_in), .data_wr(data_wr), .data_in(data_in), .bus_status_reg(bus_status_reg),
		.bus_data_reg(bus_data_reg), .step_done(step_done), .write_collision_flag(write_collision_flag),
		.halt_column(halt_column), .begin_column(begin_column), .ack_on_bit(ack_on_bit),
		.master_send_mode(master_send_mode), .master_receive_mode(master_receive_mode),
		.slave_entry(slave_entry), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
	tww_slave_model far_side (.scl(scl_line), .sda(sda_line), .ack_en(ack_en), .stretch(stretch),
		.rival_en(rival_en), .rival(rival), .scl_pull(scl_pull), .sda_pull(sda_pull),
		.last_byte(last_byte), .nbytes(nbytes));
	// ------------------------------------------------------------
	// clocks: 5 ns system, 30 ns link with an unrelated phase
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7.3;
		forever #15 link_clk = ~link_clk;
	end
	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (20) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (30) @(negedge sys_clk);
	endtask
	// control write with enable and clear set
	task automatic ctl(input logic b, input logic h);
		@(negedge sys_clk);
		ctrl_in = '{1'b1, b, h, 1'b1, 1'b0};
		ctrl_wr = 1'b1;
		@(negedge sys_clk);
		ctrl_wr = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic dwr(input logic [7:0] v);
		@(negedge sys_clk);
		data_in = v;
		data_wr = 1'b1;
		@(negedge sys_clk);
		data_wr = 1'b0;
		@(negedge sys_clk);
	endtask
	// bounded wait on the step-done flag
	task automatic wait_done();
		int n;
		n = 0;
		while (step_done !== 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		check({7'h00, step_done}, 8'h01);
	endtask
	task automatic step(input logic b, input logic h, input logic [7:0] exp);
		ctl(b, h);
		wait_done();
		check(bus_status_reg & ST_CODE_MASK, exp);
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int n;
		sys_rst = 1'b1;
		ctrl_wr = 1'b0;
		data_wr = 1'b0;
		ctrl_in = '0;
		data_in = 8'h00;
		ack_en = 1'b1;
		stretch = 1'b0;
		rival_en = 1'b0;
		rival = 8'h00;
		errors = 0;
		checks_done = 0;
		do_reset();
		check(bus_status_reg, ST_IDLE);
		check({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
		check({5'h00, scl_out, sda_out, ack_on_bit}, 8'h00);
		// start, then a data write while the flag is low
		ctl(1'b1, 1'b0);
		check({6'h00, begin_column, halt_column}, 8'h02);
		dwr(8'h11);
		check({7'h00, write_collision_flag}, 8'h01);
		check(bus_data_reg, 8'h00);
		wait_done();
		check(bus_status_reg & ST_CODE_MASK, ST_START);
		check(bus_status_reg & 8'h07, 8'h00);
		// flag high keeps the bus waiting
		repeat (300) @(negedge sys_clk);
		check(bus_status_reg, ST_START);
		check(nbytes, 8'h00);
		dwr(8'ha0);
		check({7'h00, write_collision_flag}, 8'h00);
		check(bus_data_reg, 8'ha0);
		step(1'b0, 1'b0, ST_AW_ACK);
		check(last_byte, 8'ha0);
		check({7'h00, master_send_mode}, 8'h01);
		dwr(8'h3c);
		step(1'b0, 1'b0, ST_D_ACK);
		check(last_byte, 8'h3c);
		// slow, unanswered data byte
		ack_en = 1'b0;
		stretch = 1'b1;
		dwr(8'hc3);
		step(1'b0, 1'b0, ST_D_NAK);
		stretch = 1'b0;
		step(1'b1, 1'b0, ST_RSTART);
		dwr(8'ha0);
		step(1'b0, 1'b0, ST_AW_NAK);
		ack_en = 1'b1;
		step(1'b1, 1'b1, ST_START);
		check({7'h00, halt_column}, 8'h00);
		dwr(8'ha0);
		step(1'b0, 1'b0, ST_AW_ACK);
		step(1'b1, 1'b0, ST_RSTART);
		dwr(8'ha1);
		step(1'b0, 1'b0, ST_AR_ACK);
		check(last_byte, 8'ha1);
		check({7'h00, master_receive_mode}, 8'h01);
		// stop, flag stays low and halt self-clears
		ctl(1'b0, 1'b1);
		n = 0;
		while (halt_column !== 1'b0 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (100) @(negedge sys_clk);
		check({6'h00, halt_column, step_done}, 8'h00);
		check(bus_status_reg, ST_IDLE);
		// arbitration lost to a rival address
		rival = 8'h20;
		rival_en = 1'b1;
		ctl(1'b1, 1'b0);
		wait_done();
		dwr(8'ha0);
		step(1'b0, 1'b0, ST_ARB);
		repeat (200) @(negedge sys_clk);
		check(last_byte, 8'h20);
		ctl(1'b0, 1'b0);
		check(bus_status_reg, ST_IDLE);
		// lost while the rival addresses this device
		rival = {DUT.OWN_ADDR, 1'b1};
		ctl(1'b1, 1'b0);
		wait_done();
		dwr(8'ha0);
		step(1'b0, 1'b0, ST_SLV);
		check({7'h00, slave_entry}, 8'h01);
		print_verdict();
	end
endmodule
